// File: src/du_pkg.sv
// Constants shared by the dual serial channel host and pin logic
package du_pkg;
   // Channel count and bus widths
   localparam int DU_NCH = 2;
   localparam int DU_DW = 8;
   localparam int DU_AW = 3;
   // Host bundle width: read, write, two selects, address, data
   localparam int DU_HOST_W = 4 + DU_AW + DU_DW;
   // Modem pin bundle width: cts, dsr, ri, cd, rx
   localparam int DU_PIN_W = 5;
   // Register offsets on the three address inputs
   localparam logic [2:0] DU_A_DATA = 3'h0;
   localparam logic [2:0] DU_A_IEN = 3'h1;
   localparam logic [2:0] DU_A_IDFC = 3'h2;
   localparam logic [2:0] DU_A_LCTL = 3'h3;
   localparam logic [2:0] DU_A_MCTL = 3'h4;
   localparam logic [2:0] DU_A_LSTAT = 3'h5;
   localparam logic [2:0] DU_A_MSTAT = 3'h6;
   localparam logic [2:0] DU_A_SCRATCH = 3'h7;
   // Modem control fields
   localparam int DU_MC_DTR = 0;
   localparam int DU_MC_RTS = 1;
   localparam int DU_MC_OUTEN = 3;
   localparam int DU_MC_LOOP = 4;
   // Enhanced feature fields
   localparam int DU_EF_ARTS = 6;
   localparam int DU_EF_ACTS = 7;
   // Interrupt enable fields
   localparam int DU_IE_RXD = 0;
   localparam int DU_IE_TXE = 1;
   localparam int DU_IE_LSE = 2;
   localparam int DU_IE_MSE = 3;
   // FIFO control fields
   localparam int DU_FC_EN = 0;
   localparam int DU_FC_DMA = 3;
   // Line control value that opens the enhanced feature register
   localparam logic [7:0] DU_LCR_KEY = 8'hbf;
   // Interrupt identification codes, highest priority first
   localparam logic [3:0] DU_ID_LINE = 4'h6;
   localparam logic [3:0] DU_ID_RXD = 4'h4;
   localparam logic [3:0] DU_ID_TXE = 4'h2;
   localparam logic [3:0] DU_ID_MODEM = 4'h0;
   localparam logic [3:0] DU_ID_NONE = 4'h1;
   // Reset values
   localparam logic [7:0] DU_RST_BYTE = 8'h00;
   localparam logic [DU_HOST_W-1:0] DU_HOST_IDLE = {4'hf, 3'h0, 8'h00};
   localparam logic [DU_PIN_W-1:0] DU_PIN_IDLE = 5'h1f;
endpackage

// File: src/du_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module du_sync
   import du_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// File: src/du_pins.sv
// Host strobe port, modem pins, ready outputs and loop-back for two channels
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module du_pins
   import du_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host strobed port
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic channel_a_select_n,
   input wire logic channel_b_select_n,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe_n,
   // Interrupt and user outputs
   output logic channel_a_irq,
   output logic channel_a_irq_oe_n,
   output logic channel_b_irq,
   output logic channel_b_irq_oe_n,
   output logic channel_a_user_out_n,
   output logic channel_b_user_out_n,
   // DMA ready outputs
   output logic channel_a_rx_ready_n,
   output logic channel_a_tx_ready_n,
   output logic channel_b_rx_ready_n,
   output logic channel_b_tx_ready_n,
   // Modem pins, index 0 is channel a
   input wire logic [1:0] cts_n,
   input wire logic [1:0] dsr_n,
   input wire logic [1:0] ri_n,
   input wire logic [1:0] cd_n,
   output logic [1:0] rts_n,
   output logic [1:0] dtr_n,
   // Serial pins
   input wire logic [1:0] rx_pin,
   output logic [1:0] tx_pin,
   // Core side: receive FIFO
   input wire logic [15:0] rx_fifo_data,
   input wire logic [1:0] rx_fifo_empty,
   input wire logic [1:0] rx_fifo_trig,
   input wire logic [1:0] rx_line_error,
   output logic [1:0] rx_fifo_pop,
   // Core side: transmit FIFO
   input wire logic [1:0] tx_fifo_empty,
   input wire logic [1:0] tx_fifo_full,
   input wire logic [1:0] tx_fifo_trig,
   output logic [1:0] tx_fifo_push,
   output logic [15:0] tx_fifo_data,
   // Core side: serial data and flow control
   input wire logic [1:0] tx_serial,
   input wire logic [1:0] auto_rts_n,
   output logic [1:0] rx_serial,
   output logic [1:0] auto_cts_en
);
   // ==========================================================
   // Host strobe synchronisation
   // ==========================================================
   logic [DU_HOST_W-1:0] host_sync;
   logic rd_n_s;
   logic wr_n_s;
   logic [1:0] cs_n_s;
   logic [2:0] addr_s;
   logic [7:0] din_s;
   logic rd_n_prev_reg;
   logic wr_n_prev_reg;
   logic rd_fall;
   logic wr_rise;
   logic [1:0] sel;

   du_sync #(.W(DU_HOST_W), .INIT(DU_HOST_IDLE)) u_host_sync
   (
      .clk(clk),
      .reset(reset),
      .async_in({host_read_strobe_n, host_write_strobe_n, channel_b_select_n,
                 channel_a_select_n, host_addr, host_data_in}),
      .sync_out(host_sync)
   );

   // Unpack the synchronised bundle
   assign {rd_n_s, wr_n_s, cs_n_s, addr_s, din_s} = host_sync;

   // Strobe history for edge detection
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rd_n_prev_reg <= 1'b1;
         wr_n_prev_reg <= 1'b1;
      end
      else
      begin
         rd_n_prev_reg <= rd_n_s;
         wr_n_prev_reg <= wr_n_s;
      end
   end

   // Edges of the strobes; channel a wins if both selects are low
   assign rd_fall = rd_n_prev_reg & ~rd_n_s;
   assign wr_rise = ~wr_n_prev_reg & wr_n_s;
   assign sel[0] = ~cs_n_s[0];
   assign sel[1] = ~cs_n_s[1] & cs_n_s[0];

   // ==========================================================
   // Per-channel registers and pins
   // ==========================================================
   logic [7:0] rd_mux [DU_NCH];
   logic [DU_NCH-1:0] irq_reg;
   logic [DU_NCH-1:0] irq_oe_n_reg;
   logic [DU_NCH-1:0] user_n_reg;
   logic [DU_NCH-1:0] rxr_n_reg;
   logic [DU_NCH-1:0] txr_n_reg;

   genvar ch;
   generate
      for (ch = 0; ch < DU_NCH; ch++)
      begin : g_ch
         logic [7:0] ier_reg;
         logic [7:0] lcr_reg;
         logic [7:0] mcr_reg;
         logic [7:0] efr_reg;
         logic [7:0] fcr_reg;
         logic [7:0] spr_reg;
         logic [3:0] delta_reg;
         logic [3:0] modem_prev_reg;
         logic [DU_PIN_W-1:0] pin_s;
         logic [3:0] modem_lvl;
         logic [3:0] delta_set;
         logic rx_s;
         logic [3:0] iid;
         logic wr_here;
         logic rd_here;

         // Independent synchroniser per channel
         du_sync #(.W(DU_PIN_W), .INIT(DU_PIN_IDLE)) u_pin_sync
         (
            .clk(clk),
            .reset(reset),
            .async_in({cd_n[ch], ri_n[ch], dsr_n[ch], cts_n[ch], rx_pin[ch]}),
            .sync_out(pin_s)
         );

         // Status order: cd, ri, dsr, cts, all shown active high
         assign modem_lvl = ~pin_s[4:1];
         assign rx_s = pin_s[0];
         assign wr_here = wr_rise & sel[ch];
         assign rd_here = rd_fall & sel[ch];

         // Changes on cd, dsr, cts; ri only on its trailing edge
         assign delta_set[0] = modem_lvl[0] ^ modem_prev_reg[0];
         assign delta_set[1] = modem_lvl[1] ^ modem_prev_reg[1];
         assign delta_set[2] = ~modem_lvl[2] & modem_prev_reg[2];
         assign delta_set[3] = modem_lvl[3] ^ modem_prev_reg[3];

         // Host writes; enhanced register hides behind the line control key
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               ier_reg <= DU_RST_BYTE;
               lcr_reg <= DU_RST_BYTE;
               mcr_reg <= DU_RST_BYTE;
               efr_reg <= DU_RST_BYTE;
               fcr_reg <= DU_RST_BYTE;
               spr_reg <= DU_RST_BYTE;
            end
            else if (wr_here)
            begin
               unique case (addr_s)
                  DU_A_IEN: ier_reg <= din_s;
                  DU_A_IDFC:
                  begin
                     if (lcr_reg == DU_LCR_KEY)
                        efr_reg <= din_s;
                     else
                        fcr_reg <= din_s;
                  end
                  DU_A_LCTL: lcr_reg <= din_s;
                  DU_A_MCTL: mcr_reg <= din_s;
                  DU_A_SCRATCH: spr_reg <= din_s;
                  default: ;
               endcase
            end
         end

         // Transmit data push; bit 0 goes out first on the line
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               tx_fifo_push[ch] <= 1'b0;
               tx_fifo_data[ch*8 +: 8] <= DU_RST_BYTE;
            end
            else
            begin
               tx_fifo_push[ch] <= wr_here && addr_s == DU_A_DATA;
               if (wr_here && addr_s == DU_A_DATA)
                  tx_fifo_data[ch*8 +: 8] <= din_s;
            end
         end

         // Receive pop on a read of the data register
         always_ff @(posedge clk)
         begin
            if (reset)
               rx_fifo_pop[ch] <= 1'b0;
            else
               rx_fifo_pop[ch] <= rd_here && addr_s == DU_A_DATA;
         end

         // Modem change flags; a new change beats the read that clears
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               delta_reg <= 4'h0;
               modem_prev_reg <= 4'h0;
            end
            else
            begin
               modem_prev_reg <= modem_lvl;
               if (rd_here && addr_s == DU_A_MSTAT)
                  delta_reg <= delta_set;
               else
                  delta_reg <= delta_reg | delta_set;
            end
         end

         // Interrupt priority: line error, data, space, modem
         always_comb
         begin
            if (ier_reg[DU_IE_LSE] && rx_line_error[ch])
               iid = DU_ID_LINE;
            else if (ier_reg[DU_IE_RXD] && !rx_fifo_empty[ch])
               iid = DU_ID_RXD;
            else if (ier_reg[DU_IE_TXE] && tx_fifo_empty[ch])
               iid = DU_ID_TXE;
            else if (ier_reg[DU_IE_MSE] && delta_reg != 4'h0)
               iid = DU_ID_MODEM;
            else
               iid = DU_ID_NONE;
         end

         // Register read selection
         always_comb
         begin
            unique case (addr_s)
               DU_A_DATA: rd_mux[ch] = rx_fifo_data[ch*8 +: 8];
               DU_A_IEN: rd_mux[ch] = ier_reg;
               DU_A_IDFC:
               begin
                  if (lcr_reg == DU_LCR_KEY)
                     rd_mux[ch] = efr_reg;
                  else
                     rd_mux[ch] = {{2{fcr_reg[DU_FC_EN]}}, 2'b00, iid};
               end
               DU_A_LCTL: rd_mux[ch] = lcr_reg;
               DU_A_MCTL: rd_mux[ch] = mcr_reg;
               DU_A_LSTAT: rd_mux[ch] = {rx_line_error[ch], tx_fifo_empty[ch],
                                        ~tx_fifo_full[ch], 4'h0, ~rx_fifo_empty[ch]};
               DU_A_MSTAT: rd_mux[ch] = {modem_lvl[3], modem_lvl[2], modem_lvl[1],
                                        modem_lvl[0], delta_reg};
               DU_A_SCRATCH: rd_mux[ch] = spr_reg;
            endcase
         end

         // Interrupt pin enable and user output follow modem control bit 3
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               irq_reg[ch] <= 1'b0;
               irq_oe_n_reg[ch] <= 1'b1;
               user_n_reg[ch] <= 1'b1;
            end
            else
            begin
               irq_reg[ch] <= iid != DU_ID_NONE;
               irq_oe_n_reg[ch] <= ~mcr_reg[DU_MC_OUTEN];
               user_n_reg[ch] <= ~mcr_reg[DU_MC_OUTEN];
            end
         end

         // Modem outputs; auto flow only when its enhanced bit is set
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               rts_n[ch] <= 1'b1;
               dtr_n[ch] <= 1'b1;
               auto_cts_en[ch] <= 1'b0;
            end
            else
            begin
               if (efr_reg[DU_EF_ARTS])
                  rts_n[ch] <= ~mcr_reg[DU_MC_RTS] | auto_rts_n[ch];
               else
                  rts_n[ch] <= ~mcr_reg[DU_MC_RTS];
               dtr_n[ch] <= ~mcr_reg[DU_MC_DTR];
               auto_cts_en[ch] <= efr_reg[DU_EF_ACTS];
            end
         end

         // Serial routing; reset holds both lines at mark, loop-back holds tx_pin at mark and feeds tx_serial to rx_serial
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               tx_pin[ch] <= 1'b1;
               rx_serial[ch] <= 1'b1;
            end
            else if (mcr_reg[DU_MC_LOOP])
            begin
               tx_pin[ch] <= 1'b1;
               rx_serial[ch] <= tx_serial[ch];
            end
            else
            begin
               tx_pin[ch] <= tx_serial[ch];
               rx_serial[ch] <= rx_s;
            end
         end

         // DMA ready outputs; receive ignores the mode, transmit mode 1 uses trigger levels, mode 0 single bytes
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               rxr_n_reg[ch] <= 1'b1;
               txr_n_reg[ch] <= 1'b0;
            end
            else
            begin
               rxr_n_reg[ch] <= rx_fifo_empty[ch] & ~rx_fifo_trig[ch];
               if (fcr_reg[DU_FC_DMA] && fcr_reg[DU_FC_EN])
               begin
                  if (tx_fifo_full[ch])
                     txr_n_reg[ch] <= 1'b1;
                  else if (tx_fifo_trig[ch] || tx_fifo_empty[ch])
                     txr_n_reg[ch] <= 1'b0;
               end
               else
                  txr_n_reg[ch] <= ~tx_fifo_empty[ch];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Host data bus drive
   // ==========================================================
   // Bus is driven only while the strobe stays low on a selected channel
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         host_data_out <= DU_RST_BYTE;
         host_data_oe_n <= 1'b1;
      end
      else
      begin
         if (rd_fall && sel[0])
            host_data_out <= rd_mux[0];
         else if (rd_fall && sel[1])
            host_data_out <= rd_mux[1];
         if (rd_fall && (sel[0] || sel[1]))
            host_data_oe_n <= 1'b0;
         else if (rd_n_s)
            host_data_oe_n <= 1'b1;
      end
   end

   // ==========================================================
   // Named channel outputs, all from flip-flops
   // ==========================================================
   assign channel_a_irq = irq_reg[0];
   assign channel_b_irq = irq_reg[1];
   assign channel_a_irq_oe_n = irq_oe_n_reg[0];
   assign channel_b_irq_oe_n = irq_oe_n_reg[1];
   assign channel_a_user_out_n = user_n_reg[0];
   assign channel_b_user_out_n = user_n_reg[1];
   assign channel_a_rx_ready_n = rxr_n_reg[0];
   assign channel_b_rx_ready_n = rxr_n_reg[1];
   assign channel_a_tx_ready_n = txr_n_reg[0];
   assign channel_b_tx_ready_n = txr_n_reg[1];
endmodule

// File: sim/du_pins_monitor.sv
// Concurrent checks on the host port and pin outputs of the dual channel block
`timescale 1ns/10ps
module du_pins_monitor
   import du_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host port
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic channel_a_select_n,
   input wire logic channel_b_select_n,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_data_in,
   input wire logic host_data_oe_n,
   // Pin outputs
   input wire logic channel_a_irq_oe_n,
   input wire logic channel_b_irq_oe_n,
   input wire logic channel_a_user_out_n,
   input wire logic channel_b_user_out_n,
   input wire logic channel_a_rx_ready_n,
   input wire logic channel_b_rx_ready_n,
   input wire logic channel_a_tx_ready_n,
   input wire logic [1:0] rts_n,
   input wire logic [1:0] tx_pin,
   // Core side
   input wire logic [1:0] rx_fifo_empty,
   input wire logic [1:0] rx_fifo_trig,
   input wire logic [1:0] tx_fifo_empty,
   input wire logic [1:0] tx_fifo_full,
   input wire logic [1:0] tx_fifo_push,
   input wire logic [15:0] tx_fifo_data
);
   // ======================================================
   // Strobe events
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic any_sel;
   // Either channel picked by the host
   assign any_sel = !channel_a_select_n || !channel_b_select_n;
   sequence rd_fall_sel;
      $fell(host_read_strobe_n) && any_sel;
   endsequence
   sequence rd_fall_none;
      $fell(host_read_strobe_n) && !any_sel;
   endsequence
   sequence wr_rise_a_data;
      $rose(host_write_strobe_n) && !channel_a_select_n && host_addr == DU_A_DATA;
   endsequence
   // ======================================================
   // Assertions
   a_user_oe_a: assert property (channel_a_irq_oe_n == channel_a_user_out_n)
      else $error("channel a user out and irq enable disagree");
   a_user_oe_b: assert property (channel_b_irq_oe_n == channel_b_user_out_n)
      else $error("channel b user out and irq enable disagree");
   a_reset_outs: assert property (disable iff (1'b0) reset |=> channel_a_user_out_n
      && channel_b_user_out_n && channel_a_irq_oe_n && channel_b_irq_oe_n
      && rts_n == 2'h3 && tx_pin == 2'h3)
      else $error("outputs not at reset level");
   a_rx_idle_a: assert property ((rx_fifo_empty[0] && !rx_fifo_trig[0]) [*3] |-> channel_a_rx_ready_n)
      else $error("rx ready low with empty fifo");
   a_rx_busy_a: assert property ((!rx_fifo_empty[0] || rx_fifo_trig[0]) [*3] |-> !channel_a_rx_ready_n)
      else $error("rx ready high with data");
   a_rx_ready_b: assert property ($stable(rx_fifo_empty[1] & ~rx_fifo_trig[1]) [*2]
      |-> channel_b_rx_ready_n == (rx_fifo_empty[1] & ~rx_fifo_trig[1]))
      else $error("channel b rx ready wrong");
   a_tx_full_high: assert property (tx_fifo_full[0] [*3] |-> channel_a_tx_ready_n)
      else $error("tx ready low while fifo full");
   a_tx_empty_low: assert property ((tx_fifo_empty[0] && !tx_fifo_full[0]) [*3]
      |-> !channel_a_tx_ready_n)
      else $error("tx ready high while fifo empty");
   a_read_answer: assert property (rd_fall_sel |-> ##3 !host_data_oe_n)
      else $error("read data not driven in time");
   a_read_release: assert property ($rose(host_read_strobe_n) |-> ##3 host_data_oe_n)
      else $error("data bus not released");
   a_no_select: assert property (rd_fall_none |-> host_data_oe_n [*5])
      else $error("bus driven without a select");
   a_write_store: assert property (wr_rise_a_data |-> ##3 tx_fifo_push[0]
      && tx_fifo_data[7:0] == $past(host_data_in, 3))
      else $error("written byte not pushed");
endmodule
bind du_pins du_pins_monitor mon_u (.clk, .reset, .host_read_strobe_n, .host_write_strobe_n,
   .channel_a_select_n, .channel_b_select_n, .host_addr, .host_data_in, .host_data_oe_n,
   .channel_a_irq_oe_n, .channel_b_irq_oe_n, .channel_a_user_out_n, .channel_b_user_out_n,
   .channel_a_rx_ready_n, .channel_b_rx_ready_n, .channel_a_tx_ready_n, .rts_n, .tx_pin,
   .rx_fifo_empty, .rx_fifo_trig, .tx_fifo_empty, .tx_fifo_full, .tx_fifo_push, .tx_fifo_data);

// File: sim/du_host_model.sv
// Host processor model on the strobed register port
`timescale 1ns/10ps
module du_host_model (
   // Clock
   input wire logic clk,
   // Strobed port toward the device
   output logic host_read_strobe_n,
   output logic host_write_strobe_n,
   output logic channel_a_select_n,
   output logic channel_b_select_n,
   output logic [2:0] host_addr,
   output logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe_n
);
   // ======================================================
   // Bus cycles
   // Idle bus from time zero
   initial
   begin
      host_read_strobe_n = 1'b1;
      host_write_strobe_n = 1'b1;
      channel_a_select_n = 1'b1;
      channel_b_select_n = 1'b1;
      host_addr = 3'h0;
      host_data_in = 8'h00;
   end
   // Setup held well past the sync depth; channel 2 selects nobody
   task automatic setup(input int ch, input logic [2:0] a, input logic [7:0] dv);
      @(posedge clk);
      channel_a_select_n <= (ch != 0);
      channel_b_select_n <= (ch != 1);
      host_addr <= a;
      host_data_in <= dv;
      repeat (4) @(posedge clk);
   endtask
   task automatic finish;
      repeat (5) @(posedge clk);
      channel_a_select_n <= 1'b1;
      channel_b_select_n <= 1'b1;
   endtask
   task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] dv);
      setup(ch, a, dv);
      host_write_strobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      host_write_strobe_n <= 1'b1;
      finish();
      host_data_in <= ~dv; // Released bus must not keep the old byte
   endtask
   task automatic rd(input int ch, input logic [2:0] a, output logic [7:0] dv);
      setup(ch, a, host_data_in);
      host_read_strobe_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1 dv = host_data_oe_n ? ~host_data_out : host_data_out; // Released bus reads inverted
      @(posedge clk);
      host_read_strobe_n <= 1'b1;
      finish();
   endtask
endmodule

// File: sim/du_pins_test.sv
// Self-checking bench for the dual channel host and pin logic
`timescale 1ns/10ps
module du_pins_test
   import du_pkg::*;
;
   logic clk, reset, host_read_strobe_n, host_write_strobe_n, channel_a_select_n;
   logic channel_b_select_n, host_data_oe_n, channel_a_irq, channel_a_irq_oe_n;
   logic channel_b_irq, channel_b_irq_oe_n, channel_a_user_out_n, channel_b_user_out_n;
   logic channel_a_rx_ready_n, channel_a_tx_ready_n, channel_b_rx_ready_n, channel_b_tx_ready_n;
   logic [2:0] host_addr;
   logic [7:0] host_data_in, host_data_out, d;
   logic [1:0] cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, rx_pin, tx_pin, rx_fifo_empty;
   logic [1:0] rx_fifo_trig, rx_line_error, rx_fifo_pop, tx_fifo_empty, tx_fifo_full;
   logic [1:0] tx_fifo_trig, tx_fifo_push, tx_serial, auto_rts_n, rx_serial, auto_cts_en;
   logic [15:0] rx_fifo_data, tx_fifo_data;
   int fails, checks;
   // ======================================================
   // Instances
   du_pins dut_u (.clk, .reset, .host_read_strobe_n, .host_write_strobe_n, .channel_a_select_n,
      .channel_b_select_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe_n,
      .channel_a_irq, .channel_a_irq_oe_n, .channel_b_irq, .channel_b_irq_oe_n,
      .channel_a_user_out_n, .channel_b_user_out_n, .channel_a_rx_ready_n,
      .channel_a_tx_ready_n, .channel_b_rx_ready_n, .channel_b_tx_ready_n, .cts_n, .dsr_n,
      .ri_n, .cd_n, .rts_n, .dtr_n, .rx_pin, .tx_pin, .rx_fifo_data, .rx_fifo_empty,
      .rx_fifo_trig, .rx_line_error, .rx_fifo_pop, .tx_fifo_empty, .tx_fifo_full,
      .tx_fifo_trig, .tx_fifo_push, .tx_fifo_data, .tx_serial, .auto_rts_n, .rx_serial,
      .auto_cts_en);
   du_host_model host_u (.clk, .host_read_strobe_n, .host_write_strobe_n, .channel_a_select_n,
      .channel_b_select_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe_n);
   // ======================================================
   // Helpers
   always #5 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Pin paths pass two sync flops plus flag and output stages
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tx_step(input logic e, input logic f, input logic t, input logic x);
      @(posedge clk);
      tx_fifo_empty[0] <= e;
      tx_fifo_full[0] <= f;
      tx_fifo_trig[0] <= t;
      wait_n(6);
      chk(channel_a_tx_ready_n, x);
   endtask
   // ======================================================
   // Scenarios
   task automatic t_reset;
      wait_n(2);
      chk({channel_a_user_out_n, channel_b_user_out_n}, 2'h3);
      chk({channel_a_irq_oe_n, channel_b_irq_oe_n, channel_a_irq, channel_b_irq}, 4'hc);
      chk(rts_n, 2'h3);
      chk({tx_pin, rx_serial, dtr_n, host_data_oe_n}, 7'h7f);
      chk({channel_b_rx_ready_n, channel_b_tx_ready_n}, 2'h2);
   endtask
   task automatic t_outen;
      host_u.wr(0, DU_A_MCTL, 8'h08);
      wait_n(3);
      chk({channel_a_irq_oe_n, channel_a_user_out_n, channel_b_user_out_n}, 3'h1);
      host_u.wr(0, DU_A_MCTL, 8'h00);
      wait_n(3);
      chk({channel_a_irq_oe_n, channel_a_user_out_n}, 2'h3);
   endtask
   // Auto request held at halt: must not matter until enabled
   task automatic t_rts;
      host_u.wr(1, DU_A_MCTL, 8'h02);
      wait_n(3);
      chk(rts_n, 2'h1);
      host_u.wr(1, DU_A_MCTL, 8'h00);
      wait_n(3);
      chk(rts_n, 2'h3);
      host_u.wr(0, DU_A_LCTL, DU_LCR_KEY);
      host_u.wr(0, DU_A_IDFC, 8'h40);
      host_u.wr(0, DU_A_LCTL, 8'h00);
      host_u.wr(0, DU_A_MCTL, 8'h02);
      wait_n(3);
      chk(rts_n[0], 1'b1);
      @(posedge clk);
      auto_rts_n <= 2'h2;
      wait_n(6);
      chk(rts_n[0], 1'b0);
      host_u.wr(0, DU_A_MCTL, 8'h00);
   endtask
   task automatic t_regs;
      host_u.wr(0, DU_A_SCRATCH, 8'ha5);
      host_u.wr(1, DU_A_SCRATCH, 8'h3c);
      host_u.wr(2, DU_A_SCRATCH, 8'hff);
      host_u.rd(0, DU_A_SCRATCH, d);
      chk(d, 8'ha5);
      host_u.rd(1, DU_A_SCRATCH, d);
      chk(d, 8'h3c);
      host_u.rd(2, DU_A_SCRATCH, d);
      chk(d, 8'hc3);
      host_u.wr(0, DU_A_DATA, 8'h01);
      chk(tx_fifo_data[7:0], 8'h01);
   endtask
   task automatic t_loop;
      host_u.wr(0, DU_A_MCTL, 8'h10);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk);
         tx_serial <= {2{v[0]}};
         rx_pin <= {2{~v[0]}};
         wait_n(6);
         chk(rx_serial, {~v[0], v[0]});
         chk(tx_pin, {v[0], 1'b1});
      end
      host_u.wr(0, DU_A_MCTL, 8'h00);
   endtask
   task automatic t_irq;
      host_u.wr(0, DU_A_IEN, 8'h08);
      host_u.wr(0, DU_A_MCTL, 8'h08);
      @(posedge clk);
      ri_n[0] <= 1'b0;
      wait_n(6);
      chk(channel_a_irq, 1'b0);
      host_u.rd(0, DU_A_MSTAT, d);
      chk(d[6], 1'b1);
      @(posedge clk);
      ri_n[0] <= 1'b1;
      wait_n(6);
      chk(channel_a_irq, 1'b1);
      host_u.rd(0, DU_A_MSTAT, d);
      wait_n(3);
      chk(channel_a_irq, 1'b0);
      host_u.wr(0, DU_A_IEN, 8'h01);
      @(posedge clk);
      rx_fifo_empty[0] <= 1'b0;
      wait_n(6);
      chk(channel_a_irq, 1'b1);
      @(posedge clk);
      rx_fifo_empty[0] <= 1'b1;
      rx_line_error[0] <= 1'b1;
      host_u.wr(0, DU_A_IEN, 8'h06);
      host_u.rd(0, DU_A_IDFC, d);
      chk(d[3:0], DU_ID_LINE);
      host_u.wr(0, DU_A_MCTL, 8'h00);
   endtask
   task automatic t_ready;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         rx_fifo_empty <= {2{i[1]}};
         rx_fifo_trig <= {2{i[0]}};
         wait_n(6);
         chk({channel_a_rx_ready_n, channel_b_rx_ready_n}, {2{i[1] & ~i[0]}});
      end
      tx_step(1'b0, 1'b0, 1'b0, 1'b1);
      tx_step(1'b1, 1'b0, 1'b0, 1'b0);
      host_u.wr(0, DU_A_IDFC, 8'h09);
      tx_step(1'b0, 1'b1, 1'b0, 1'b1);
      tx_step(1'b0, 1'b0, 1'b0, 1'b1);
      tx_step(1'b0, 1'b0, 1'b1, 1'b0);
      tx_step(1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   // ======================================================
   // Main sequence and watchdog
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {cts_n, dsr_n, ri_n, cd_n, rx_pin, rx_fifo_empty, tx_fifo_empty} = 14'h3fff;
      {rx_fifo_trig, rx_line_error, tx_fifo_full, tx_fifo_trig, tx_serial} = 10'h003;
      auto_rts_n = 2'h3;
      rx_fifo_data = 16'h0000;
      fails = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_outen();
      t_rts();
      t_regs();
      t_loop();
      t_irq();
      t_ready();
      wrap_up();
   end
   // Whole run is a few hundred cycles; this span is ample
   initial
   begin
      #400000;
      fails++;
      wrap_up();
   end
endmodule
